// file: hdl/tefl_top.sv
// timer event flags, interrupt and dma requests, software event generation
// assumes a counter core, capture stages and output stages on the same clock
//
// Function
// - dma enables bits 14..8 gate dma requests
// - interrupt enables bits 7..0 gate interrupts
// - flags set by hardware, cleared writing zero
// - overcapture flag on capture while flag set
// - break flag set; clear fails while active
// - trigger flag on edge; both edges gated
// - commutation flag set when control bits load
// - output channel flag on compare match
// - input flag on capture; read clears
// - update flag on overflow or reinitialisation
// - generate bits self clear; zero ignored
// - force break clears main output, sets flag
// - force trigger sets trigger flag
// - force commutation loads only with preload
// - force channel event on output sets flag
// - force channel event on input captures counter
// - force update reinitialises counter and shadows
// - trigger rising edge commutates when selected, only with preload
//
// Register access over Wishbone was chosen for this implementation.

module tefl_top
  import tefl_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  // wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADR_W-1:0]  WB_ADR_I,
  input  wire logic [31:0]       WB_DAT_I,
  input  wire logic [3:0]        WB_SEL_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // counter core
  input  wire logic              OVERFLOW_EVENT,
  input  wire logic              TRIGGER_REINIT_EVENT,
  input  wire logic              UPDATE_REQUEST_SOURCE,
  input  wire logic              UPDATE_DISABLE,
  input  wire logic              COUNT_DOWN,
  input  wire logic [1:0]        CENTER_ALIGN_SELECT,
  // slave controller
  input  wire logic              TRIGGER_INPUT,
  input  wire logic [2:0]        SLAVE_MODE,
  // channels
  input  wire logic [CH_N-1:0]   CHANNEL_IS_INPUT,
  input  wire logic [CH_N-1:0]   CAPTURE_EDGE,
  input  wire logic [CH_N-1:0]   COMPARE_MATCH,
  input  wire logic [CH_N-1:0]   CAPTURE_READ,
  // break and commutation
  input  wire logic              BREAK_INPUT,
  input  wire logic              PRELOADED_CONTROL_ENABLE,
  input  wire logic              COMMUTATION_SOURCE_SELECT,
  // requests and strobes
  output logic      [IRQ_N-1:0]  IRQ_REQ,
  output logic      [DMA_N-1:0]  DMA_REQ,
  output logic                   FORCE_UPDATE,
  output logic                   RELOAD_FROM_AUTO,
  output logic      [CH_N-1:0]   CAPTURE_LOAD,
  output logic                   COMMUTATION_LOAD,
  output logic                   MAIN_OUTPUT_CLEAR
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [REG_W-1:0] req_enable;
    logic [REG_W-1:0] status;
    logic [GEN_W-1:0] generate_req;
    logic             trig_prev;
    logic [DMA_N-1:0] dma;
  } tefl_state_t;

  tefl_state_t st_r;
  tefl_state_t st_nxt;

  tefl_reg_if  reg_bus ();

  // ****************************************************************
  // helpers
  // ****************************************************************
  // low two byte lanes widened to a 16-bit bit mask
  function automatic logic [REG_W-1:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  tefl_wb_slave u_wb_slave (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .cyc_i (WB_CYC_I),
    .stb_i (WB_STB_I),
    .we_i  (WB_WE_I),
    .adr_i (WB_ADR_I),
    .dat_i (WB_DAT_I),
    .sel_i (WB_SEL_I),
    .dat_o (WB_DAT_O),
    .ack_o (WB_ACK_O),
    .regs  (reg_bus.bus_mp)
  );

  // ****************************************************************
  // event decode
  // ****************************************************************
  logic             sw_update;
  logic [CH_N-1:0]  sw_channel;
  logic             sw_commut;
  logic             sw_trigger;
  logic             sw_break;
  logic             trig_rise;
  logic             trig_fall;
  logic             ev_trigger;
  logic             ev_commut;
  logic             ev_update;
  logic             ev_break;
  logic [CH_N-1:0]  ev_capture;
  logic [CH_N-1:0]  ev_compare;
  logic [CH_N-1:0]  ev_channel;
  logic [CH_N-1:0]  ev_overcap;
  logic [IRQ_N-1:0] ev_all;

  always_comb begin
    // generate bits live one cycle in the register
    sw_update  = st_r.generate_req[BIT_UPDATE];
    sw_channel = st_r.generate_req[BIT_CH0 +: CH_N];
    sw_commut  = st_r.generate_req[BIT_COMMUT];
    sw_trigger = st_r.generate_req[BIT_TRIGGER];
    sw_break   = st_r.generate_req[BIT_BREAK];

    trig_rise  = TRIGGER_INPUT & ~st_r.trig_prev;
    trig_fall  = ~TRIGGER_INPUT & st_r.trig_prev;
    ev_trigger = sw_trigger;
    if (SLAVE_MODE == SMS_GATED) begin
      ev_trigger = ev_trigger | trig_rise | trig_fall;
    end else if (SLAVE_MODE != SMS_DISABLED) begin
      ev_trigger = ev_trigger | trig_rise;
    end

    // commutation only while control bits are preloaded
    ev_commut = PRELOADED_CONTROL_ENABLE &
                (sw_commut | (COMMUTATION_SOURCE_SELECT & trig_rise));

    ev_update = (OVERFLOW_EVENT & ~UPDATE_DISABLE) |
                ((sw_update | TRIGGER_REINIT_EVENT) &
                 ~UPDATE_REQUEST_SOURCE & ~UPDATE_DISABLE);

    // break level keeps setting the flag, so a clear cannot win
    ev_break = BREAK_INPUT | sw_break;

    ev_capture = CHANNEL_IS_INPUT & (CAPTURE_EDGE | sw_channel);
    ev_compare = ~CHANNEL_IS_INPUT & (COMPARE_MATCH | sw_channel);
    ev_channel = ev_capture | ev_compare;
    ev_overcap = ev_capture & st_r.status[BIT_CH0 +: CH_N];

    ev_all = {ev_break, ev_trigger, ev_commut, ev_channel, ev_update};
  end

  // ****************************************************************
  // register file and flags
  // ****************************************************************
  logic             wr_enable;
  logic             wr_status;
  logic             wr_generate;
  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] wdata16;
  logic [REG_W-1:0] set_flags;
  logic [REG_W-1:0] clr_flags;

  always_comb begin
    st_nxt      = st_r;
    wmask       = lane_mask(reg_bus.sel);
    wdata16     = reg_bus.wdata[REG_W-1:0];
    wr_enable   = reg_bus.wr & reg_hit(reg_bus.addr, OFS_REQ_ENABLE);
    wr_status   = reg_bus.wr & reg_hit(reg_bus.addr, OFS_STATUS);
    wr_generate = reg_bus.wr & reg_hit(reg_bus.addr, OFS_GENERATE);

    if (wr_enable) begin
      st_nxt.req_enable = ((st_r.req_enable & ~wmask) | (wdata16 & wmask)) & MASK_REQ_EN;
    end

    // set and clear pulses: zero written clears, one written is ignored
    set_flags = '0;
    set_flags[IRQ_N-1:0] = ev_all;
    set_flags[BIT_OVC0 +: CH_N] = ev_overcap;
    clr_flags = '0;
    if (wr_status) begin
      clr_flags = ~wdata16 & wmask & MASK_STATUS;
    end
    // reading a capture register clears an input channel flag
    clr_flags[BIT_CH0 +: CH_N] = clr_flags[BIT_CH0 +: CH_N] |
                                 (CAPTURE_READ & CHANNEL_IS_INPUT);
    // an event in the clearing cycle wins
    st_nxt.status = ((st_r.status & ~clr_flags) | set_flags) & MASK_STATUS;

    // software writes ones; hardware drops them the next cycle
    st_nxt.generate_req = RST_GENERATE;
    if (wr_generate & reg_bus.sel[0]) begin
      st_nxt.generate_req = reg_bus.wdata[GEN_W-1:0];
    end

    st_nxt.trig_prev = TRIGGER_INPUT;
    st_nxt.dma       = ev_all[DMA_N-1:0] & st_r.req_enable[BIT_DMA_LSB +: DMA_N];
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st_r.req_enable   <= RST_REQ_ENABLE;
      st_r.status       <= RST_STATUS;
      st_r.generate_req <= RST_GENERATE;
      st_r.trig_prev    <= 1'b0;
      st_r.dma          <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    reg_bus.rdata = 32'h0000_0000;
    if (reg_hit(reg_bus.addr, OFS_REQ_ENABLE)) begin
      reg_bus.rdata[REG_W-1:0] = st_r.req_enable;
    end else if (reg_hit(reg_bus.addr, OFS_STATUS)) begin
      reg_bus.rdata[REG_W-1:0] = st_r.status;
    end
    // generate register is write only and reads zero
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign IRQ_REQ           = st_r.status[IRQ_N-1:0] & st_r.req_enable[IRQ_N-1:0];
  assign DMA_REQ           = st_r.dma;
  assign FORCE_UPDATE      = sw_update;
  // down counting in edge mode reloads from auto-reload, else from zero
  assign RELOAD_FROM_AUTO  = sw_update & COUNT_DOWN &
                             (CENTER_ALIGN_SELECT == CMS_EDGE);
  assign CAPTURE_LOAD      = ev_capture;
  assign COMMUTATION_LOAD  = ev_commut;
  assign MAIN_OUTPUT_CLEAR = sw_break;

endmodule // tefl_top

// file: hdl/tefl_wb_slave.sv
// classic wishbone slave: one wait state, registered ack and read data
// assumes a master that holds its request until it samples ack

module tefl_wb_slave
  import tefl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  tefl_reg_if.bus_mp       regs
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tefl_wb_state_t;

  tefl_wb_state_t st_r;
  tefl_wb_state_t st_nxt;

  // ****************************************************************
  // request decode
  // ****************************************************************
  // write lands on the edge that the master samples ack
  assign regs.wr    = cyc_i & stb_i & we_i & st_r.ack;
  assign regs.addr  = adr_i;
  assign regs.wdata = dat_i;
  assign regs.sel   = sel_i;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = cyc_i & stb_i & ~st_r.ack;
    st_nxt.dat = (cyc_i & stb_i & ~we_i & ~st_r.ack) ? regs.rdata : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = st_r.ack;
  assign dat_o = st_r.dat;

endmodule // tefl_wb_slave

// file: pkg/tefl_pkg.sv
// constants of the timer event, flag and request logic
// assumes a 16-bit timer core alongside and a 32-bit classic wishbone bus

package tefl_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  OFS_REQ_ENABLE = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_GENERATE   = 8'h14;

  // ****************************************************************
  // widths, reset values and implemented-bit masks
  // ****************************************************************
  localparam int          REG_W          = 16;
  localparam int          GEN_W          = 8;
  localparam int          CH_N           = 4;
  localparam int          IRQ_N          = 8;
  localparam int          DMA_N          = 7;
  localparam logic [15:0] RST_REQ_ENABLE = 16'h0000;
  localparam logic [15:0] RST_STATUS     = 16'h0000;
  localparam logic [7:0]  RST_GENERATE   = 8'h00;
  localparam logic [15:0] MASK_REQ_EN    = 16'h7fff;
  localparam logic [15:0] MASK_STATUS    = 16'h1eff;

  // ****************************************************************
  // field positions; bits 7..0 shared by enable, status and generate registers, dma lsb in enable, overcapture in status
  // ****************************************************************
  localparam int          BIT_UPDATE     = 0;
  localparam int          BIT_CH0        = 1;
  localparam int          BIT_COMMUT     = 5;
  localparam int          BIT_TRIGGER    = 6;
  localparam int          BIT_BREAK      = 7;
  localparam int          BIT_DMA_LSB    = 8;
  localparam int          BIT_OVC0       = 9;

  // ****************************************************************
  // slave controller modes and counter mode codes
  // ****************************************************************
  localparam logic [2:0]  SMS_DISABLED   = 3'h0;
  localparam logic [2:0]  SMS_GATED      = 3'h5;
  localparam logic [1:0]  CMS_EDGE       = 2'h0;

endpackage : tefl_pkg

// file: pkg/tefl_reg_if.sv
// register access carrier between the wishbone slave and the flag logic
// assumes a single clock domain shared by both ends

interface tefl_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [3:0]  sel;
  logic [31:0] rdata;

  modport bus_mp  (output wr, output addr, output wdata, output sel, input rdata);
  modport regs_mp (input wr, input addr, input wdata, input sel, output rdata);
endinterface : tefl_reg_if

// file: test/tefl_monitor.sv
// assertions on strobes and register reads of the timer flag block
// assumes binding to tefl_top, one clock and a synchronous reset
module tefl_monitor
  import tefl_pkg::*;
(
  input wire logic             MCLK,
  input wire logic             RESET_N,
  input wire logic             WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [31:0]      WB_DAT_I,
  input wire logic [3:0]       WB_SEL_I,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic             WB_ACK_O,
  input wire logic             COUNT_DOWN,
  input wire logic [1:0]       CENTER_ALIGN_SELECT,
  input wire logic             TRIGGER_INPUT,
  input wire logic [CH_N-1:0]  CHANNEL_IS_INPUT,
  input wire logic [CH_N-1:0]  CAPTURE_EDGE,
  input wire logic             PRELOADED_CONTROL_ENABLE,
  input wire logic             COMMUTATION_SOURCE_SELECT,
  input wire logic             FORCE_UPDATE,
  input wire logic             RELOAD_FROM_AUTO,
  input wire logic [CH_N-1:0]  CAPTURE_LOAD,
  input wire logic             COMMUTATION_LOAD,
  input wire logic             MAIN_OUTPUT_CLEAR
);
  // ***
  // accepted generate writes and read answers
  // ***
  default clocking dcb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  logic gen_wr;
  logic rd_ack;
  assign gen_wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == OFS_GENERATE[7:2];
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  a_update_strobe: assert property (gen_wr && WB_DAT_I[0] |=> FORCE_UPDATE ##1 !FORCE_UPDATE)
    else $error("update strobe");
  a_break_strobe: assert property (gen_wr && WB_DAT_I[7] |=> MAIN_OUTPUT_CLEAR ##1 !MAIN_OUTPUT_CLEAR)
    else $error("break strobe");
  a_reload_dir: assert property (RELOAD_FROM_AUTO == (FORCE_UPDATE && COUNT_DOWN && CENTER_ALIGN_SELECT == CMS_EDGE))
    else $error("reload direction");
  a_capture_edge: assert property ((CAPTURE_EDGE & CHANNEL_IS_INPUT & ~CAPTURE_LOAD) == 4'h0)
    else $error("capture missed");
  a_commut_preload: assert property (COMMUTATION_LOAD |-> PRELOADED_CONTROL_ENABLE)
    else $error("load without preload");
  a_commut_trig: assert property ($rose(TRIGGER_INPUT) && COMMUTATION_SOURCE_SELECT && PRELOADED_CONTROL_ENABLE |-> COMMUTATION_LOAD)
    else $error("trigger commutation");
  a_status_reserved: assert property (rd_ack && WB_ADR_I[7:2] == OFS_STATUS[7:2] |-> (WB_DAT_O & ~{16'h0, MASK_STATUS}) == 32'h0)
    else $error("status reserved");
  a_gen_reads_zero: assert property (rd_ack && WB_ADR_I[7:2] == OFS_GENERATE[7:2] |-> WB_DAT_O == 32'h0)
    else $error("generate read");
endmodule // tefl_monitor

bind tefl_top tefl_monitor tefl_monitor_inst (.MCLK(MCLK), .RESET_N(RESET_N), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .COUNT_DOWN(COUNT_DOWN), .CENTER_ALIGN_SELECT(CENTER_ALIGN_SELECT), .TRIGGER_INPUT(TRIGGER_INPUT),
  .CHANNEL_IS_INPUT(CHANNEL_IS_INPUT), .CAPTURE_EDGE(CAPTURE_EDGE), .PRELOADED_CONTROL_ENABLE(PRELOADED_CONTROL_ENABLE),
  .COMMUTATION_SOURCE_SELECT(COMMUTATION_SOURCE_SELECT), .FORCE_UPDATE(FORCE_UPDATE),
  .RELOAD_FROM_AUTO(RELOAD_FROM_AUTO), .CAPTURE_LOAD(CAPTURE_LOAD), .COMMUTATION_LOAD(COMMUTATION_LOAD),
  .MAIN_OUTPUT_CLEAR(MAIN_OUTPUT_CLEAR));

// file: test/tefl_req_sink.sv
// model of the dma controller taking the request pulses
// assumes requests sampled on the rising clock edge
module tefl_req_sink
  import tefl_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [DMA_N-1:0] dma
);
  int dma_cnt [DMA_N];
  always @(posedge clk) begin
    for (int i = 0; i < DMA_N; i++) begin
      if (!rst_n)
        dma_cnt[i] <= 0;
      else if (dma[i] === 1'b1)
        dma_cnt[i] <= dma_cnt[i] + 1;
    end
  end
endmodule // tefl_req_sink

// file: test/testbench.sv
// self-checking bench of the timer event flag block
// assumes tefl_top, its checker and the dma sink compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tefl_pkg::*;
  logic        mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ovf = 0, tre = 0, update_request_source = 0;
  logic        update_disable = 0, cdn = 0, trg = 0, brk = 0, pre = 0, commutation_source_select = 0, ack;
  logic [1:0]  center_align_select = 0;
  logic [2:0]  smode = 0;
  logic [3:0]  sel = 0, isin = 0, cape = 0, cmpm = 0, caprd = 0;
  logic [7:0]  adr = 0, irq;
  logic [6:0]  dma;
  logic [15:0] en;
  logic [31:0] dat = 0, dato, q;
  int          fails = 0, compares = 0, cycles = 0, seed = 32'h1aa0, n0, ch;
  tefl_top tefl_top_inst (.MCLK(mclk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dato), .WB_ACK_O(ack), .OVERFLOW_EVENT(ovf),
    .TRIGGER_REINIT_EVENT(tre), .UPDATE_REQUEST_SOURCE(update_request_source), .UPDATE_DISABLE(update_disable), .COUNT_DOWN(cdn),
    .CENTER_ALIGN_SELECT(center_align_select), .TRIGGER_INPUT(trg), .SLAVE_MODE(smode), .CHANNEL_IS_INPUT(isin),
    .CAPTURE_EDGE(cape), .COMPARE_MATCH(cmpm), .CAPTURE_READ(caprd), .BREAK_INPUT(brk),
    .PRELOADED_CONTROL_ENABLE(pre), .COMMUTATION_SOURCE_SELECT(commutation_source_select), .IRQ_REQ(irq), .DMA_REQ(dma),
    .FORCE_UPDATE(), .RELOAD_FROM_AUTO(), .CAPTURE_LOAD(), .COMMUTATION_LOAD(), .MAIN_OUTPUT_CLEAR());
  tefl_req_sink tefl_req_sink_inst (.clk(mclk), .rst_n(rst_n), .dma(dma));
  always #2 mclk = ~mclk;
  // ***
  // bus cycles and comparisons
  // ***
  function automatic logic [15:0] fl(input int i);
    return 16'h1 << i;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    sel <= 4'h3;
    do @(posedge mclk); while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0);
    chk(q, e);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end
  // ***
  // scenarios
  // ***
  initial begin
    tk(10);
    rst_n <= 1'b1;
    tk(1);
    rd(OFS_REQ_ENABLE, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_GENERATE, 32'h0);
    rd(8'h20, 32'h0);
    $display("test 1 done");
    pre <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      en = (k == 0) ? 16'hffff : 16'($random(seed));
      cdn <= ~k[0];
      center_align_select <= k[1:0];
      wb(1'b1, OFS_REQ_ENABLE, en);
      en = en & MASK_REQ_EN;
      rd(OFS_REQ_ENABLE, en);
      for (int i = 0; i < 7; i++) begin
        n0 = tefl_req_sink_inst.dma_cnt[i];
        wb(1'b1, OFS_GENERATE, fl(i));
        wb(1'b1, OFS_STATUS, 16'hffff);
        rd(OFS_STATUS, fl(i));
        chk(irq, en[7:0] & fl(i));
        chk(tefl_req_sink_inst.dma_cnt[i] - n0, en[8+i]);
        wb(1'b1, OFS_STATUS, ~fl(i));
        rd(OFS_STATUS, 32'h0);
      end
    end
    $display("test 2 done");
    brk <= 1'b1;
    tk(2);
    wb(1'b1, OFS_STATUS, 16'h0);
    rd(OFS_STATUS, 32'h80);
    brk <= 1'b0;
    wb(1'b1, OFS_STATUS, 16'h0);
    rd(OFS_STATUS, 32'h0);
    wb(1'b1, OFS_GENERATE, 16'h80);
    rd(OFS_STATUS, 32'h80);
    chk(irq, {en[7], 7'h0});
    wb(1'b1, OFS_STATUS, 16'h0);
    $display("test 3 done");
    isin <= 4'hf;
    ch = $random(seed) & 3;
    cape <= 4'(fl(ch));
    tk(2);
    cape <= 4'h0;
    rd(OFS_STATUS, fl(1 + ch) | fl(9 + ch));
    caprd <= 4'(fl(ch));
    tk(1);
    caprd <= 4'h0;
    rd(OFS_STATUS, fl(9 + ch));
    wb(1'b1, OFS_STATUS, 16'h0);
    wb(1'b1, OFS_GENERATE, 16'h2);
    wb(1'b1, OFS_GENERATE, 16'h2);
    rd(OFS_STATUS, 32'h202);
    wb(1'b1, OFS_STATUS, 16'h0);
    $display("test 4 done");
    isin <= 4'h0;
    smode <= SMS_GATED;
    trg <= 1'b1;
    tk(2);
    wb(1'b1, OFS_STATUS, 16'h0);
    trg <= 1'b0;
    tk(2);
    rd(OFS_STATUS, 32'h40);
    smode <= 3'h4;
    commutation_source_select <= 1'b1;
    wb(1'b1, OFS_STATUS, 16'h0);
    trg <= 1'b1;
    tk(2);
    rd(OFS_STATUS, 32'h60);
    wb(1'b1, OFS_STATUS, 16'h0);
    trg <= 1'b0;
    tk(2);
    rd(OFS_STATUS, 32'h0);
    $display("test 5 done");
    update_request_source <= 1'b1;
    tre <= 1'b1;
    tk(1);
    tre <= 1'b0;
    wb(1'b1, OFS_GENERATE, 16'h1);
    update_request_source <= 1'b0;
    update_disable <= 1'b1;
    ovf <= 1'b1;
    tk(1);
    ovf <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    update_disable <= 1'b0;
    ovf <= 1'b1;
    cmpm <= 4'h8;
    tk(1);
    ovf <= 1'b0;
    cmpm <= 4'h0;
    rd(OFS_STATUS, 32'h11);
    $display("test 6 done");
    close_out();
  end
endmodule // testbench
